// ### hw/serial_shift_defs.svh
`ifndef SERIAL_SHIFT_DEFS_SVH
`define SERIAL_SHIFT_DEFS_SVH

// register indices (byte address is four times the index)
`define SER_IDX_CONTROL    8'h0D
`define SER_IDX_STATUS     8'h0E
`define SER_IDX_DATA       8'h0F
`define SER_IDX_BUFFER     8'h10

// control field positions
`define CTL_START_IE_BIT   7
`define CTL_WRAP_IE_BIT    6
`define CTL_LINE_HI_BIT    5
`define CTL_LINE_LO_BIT    4
`define CTL_CLKSEL_HI_BIT  3
`define CTL_CLKSEL_LO_BIT  2
`define CTL_CLK_STROBE_BIT 1
`define CTL_TOGGLE_BIT     0

// status field positions
`define STS_START_BIT      7
`define STS_WRAP_BIT       6
`define STS_STOP_BIT       5
`define STS_MISMATCH_BIT   4
`define STS_COUNT_HI_BIT   3
`define STS_COUNT_LO_BIT   0

// reset values and counter maximum
`define SER_CONTROL_RST    8'h00
`define SER_DATA_RST       8'h00
`define SER_BUFFER_RST     8'h00
`define SER_COUNT_RST      4'h0
`define SER_COUNT_MAX      4'hF

`endif

// ### hw/serial_shift_pkg.sv
package serial_shift_pkg;

  // wire-mode choices of the line configuration field
  typedef enum logic [1:0] {
    LINE_OFF,
    LINE_THREE_WIRE,
    LINE_TWO_WIRE,
    LINE_TWO_WIRE_HOLD
  } line_mode_e;

  // clock source choices
  typedef enum logic [1:0] {
    SRC_SOFTWARE,
    SRC_TIMER0,
    SRC_EXT_RISE,
    SRC_EXT_FALL
  } clk_src_e;

  // one pin driver: level driven and output enable
  typedef struct packed {
    logic level;
    logic oe;
  } pin_drive_s;

  // stored control register
  typedef struct packed {
    logic       start_irq_enable;
    logic       wrap_irq_enable;
    line_mode_e line_config_field;
    clk_src_e   shift_clock_select;
    logic       clock_strobe_bit;
  } control_s;

endpackage

// ### hw/universal_serial_shift_core.sv
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`include "serial_shift_defs.svh"

module universal_serial_shift_core
(
  input  wire logic                        CLK_IN,
  input  wire logic                        RST_N_IN,
  // apb slave
  input  wire logic                        PSEL_IN,
  input  wire logic                        PENABLE_IN,
  input  wire logic                        PWRITE_IN,
  input  wire logic [7:0]                  PADDR_IN,
  input  wire logic [31:0]                 PWDATA_IN,
  output logic      [31:0]                 PRDATA_OUT,
  output logic                             PREADY_OUT,
  output logic                             PSLVERR_OUT,
  // serial pins (asynchronous)
  input  wire logic                        SERIAL_IN_PIN_IN,
  input  wire logic                        SHIFT_CLOCK_PIN_IN,
  // port state and system inputs, same clock
  input  wire logic                        PORT_DIR_DATA_IN,
  input  wire logic                        PORT_DIR_CLOCK_IN,
  input  wire logic                        PORT_OUT_DATA_IN,
  input  wire logic                        PORT_OUT_CLOCK_IN,
  input  wire logic                        TIMER0_MATCH_IN,
  input  wire logic                        GLOBAL_IRQ_EN_IN,
  // pin drivers
  output serial_shift_pkg::pin_drive_s     DATA_DRIVE_OUT,
  output serial_shift_pkg::pin_drive_s     CLOCK_DRIVE_OUT,
  output logic                             PIN_TOGGLE_OUT,
  // interrupts and wake
  output logic                             START_IRQ_OUT,
  output logic                             WRAP_IRQ_OUT,
  output logic                             WAKE_ANY_SLEEP_OUT,
  output logic                             WAKE_IDLE_OUT
);
  import serial_shift_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  control_s   ctl_r;
  logic [7:0] data_r;
  logic [7:0] buf_r;
  logic [3:0] cnt_r;
  logic       start_flag_r;
  logic       wrap_flag_r;
  logic       stop_flag_r;
  logic       latch_r;
  logic       start_hold_r;
  logic [31:0] prdata_r;
  logic       scl_m_r;
  logic       scl_s_r;
  logic       scl_d_r;
  logic       sda_m_r;
  logic       sda_s_r;
  logic       sda_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire        setup_rd   = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
  wire        wr_access  = PSEL_IN & PENABLE_IN & PWRITE_IN;
  wire [7:0]  reg_idx    = {2'b00, PADDR_IN[7:2]};
  wire        hit_ctl    = (reg_idx == `SER_IDX_CONTROL);
  wire        hit_sts    = (reg_idx == `SER_IDX_STATUS);
  wire        hit_data   = (reg_idx == `SER_IDX_DATA);
  wire        hit_buf    = (reg_idx == `SER_IDX_BUFFER);
  wire        mapped     = (hit_ctl | hit_sts | hit_data | hit_buf) & (PADDR_IN[1:0] == 2'b00);
  wire        wr_ctl     = wr_access & mapped & hit_ctl;
  wire        wr_sts     = wr_access & mapped & hit_sts;
  wire        wr_data    = wr_access & mapped & hit_data;
  wire [7:0]  wbyte      = PWDATA_IN[7:0];

  // zero-wait slave, error on unmapped address
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;
  assign PRDATA_OUT  = prdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, edges read from second stage onward only

  wire scl_rise = scl_s_r & ~scl_d_r;
  wire scl_fall = ~scl_s_r & scl_d_r;
  wire scl_edge = scl_rise | scl_fall;
  wire sda_rise = sda_s_r & ~sda_d_r;
  wire sda_fall = ~sda_s_r & sda_d_r;

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_m_r <= SHIFT_CLOCK_PIN_IN;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= SERIAL_IN_PIN_IN;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode

  wire two_wire   = ctl_r.line_config_field[1];
  wire wire_off   = (ctl_r.line_config_field == LINE_OFF);
  wire ext_src    = ctl_r.shift_clock_select[1];
  wire ext_fall   = (ctl_r.shift_clock_select == SRC_EXT_FALL);
  wire strobe_clk = wr_ctl & wbyte[`CTL_CLK_STROBE_BIT];
  wire toggle_wr  = wr_ctl & wbyte[`CTL_TOGGLE_BIT];
  wire strobe_sel = ctl_r.clock_strobe_bit;

  // toggle strobe goes to the port output logic for the clock pin
  assign PIN_TOGGLE_OUT = toggle_wr;

  ////////////////////////////////////////////////////////////////////////////
  // shift and count clocks

  // pin edges used in every wire mode
  wire ext_shift_edge = ext_fall ? scl_fall : scl_rise;
  wire shift_clk =
    (ctl_r.shift_clock_select == SRC_SOFTWARE) ? strobe_clk :
    (ctl_r.shift_clock_select == SRC_TIMER0)   ? TIMER0_MATCH_IN :
    strobe_sel                                 ? toggle_wr : ext_shift_edge;

  wire count_clk =
    (ctl_r.shift_clock_select == SRC_SOFTWARE) ? (strobe_clk | toggle_wr) :
    (ctl_r.shift_clock_select == SRC_TIMER0)   ? TIMER0_MATCH_IN :
    strobe_sel                                 ? toggle_wr : scl_edge;

  // wrap from F on next clock
  wire        wrap_evt  = count_clk & (cnt_r == `SER_COUNT_MAX);
  wire [7:0]  shifted   = {data_r[6:0], sda_s_r};

  wire [7:0]  data_nxt  = wr_data ? wbyte : (shift_clk ? shifted : data_r);
  wire [3:0]  cnt_nxt   = wr_sts ? wbyte[`STS_COUNT_HI_BIT:`STS_COUNT_LO_BIT] :
                          (count_clk ? cnt_r + 4'h1 : cnt_r);

  ////////////////////////////////////////////////////////////////////////////
  // flag events

  // no start detector outside the two-wire modes... edge mode instead
  wire start_evt = two_wire ? (sda_fall & scl_s_r) : scl_edge;
  wire stop_evt  = two_wire & sda_rise & scl_s_r;

  wire clr_start = wr_sts & wbyte[`STS_START_BIT];
  wire clr_wrap  = wr_sts & wbyte[`STS_WRAP_BIT];
  wire clr_stop  = wr_sts & wbyte[`STS_STOP_BIT];

  wire start_flag_nxt = start_evt | (start_flag_r & ~clr_start);
  wire wrap_flag_nxt  = wrap_evt | (wrap_flag_r & ~clr_wrap);
  wire stop_flag_nxt  = stop_evt | (stop_flag_r & ~clr_stop);

  // start hold begins when the clock falls after a start, ends with the flag
  wire start_hold_nxt = two_wire & start_flag_nxt & (start_hold_r | scl_fall);

  ////////////////////////////////////////////////////////////////////////////
  // output latch

  // open in first half of external period, always for internal
  wire latch_open = ~ext_src | (scl_s_r == ext_fall);

  ////////////////////////////////////////////////////////////////////////////
  // control register and strobes

  wire clk_sel_wr = wbyte[`CTL_CLKSEL_HI_BIT];
  control_s ctl_nxt;
  assign ctl_nxt = wr_ctl ?
    control_s'{start_irq_enable:   wbyte[`CTL_START_IE_BIT],
               wrap_irq_enable:    wbyte[`CTL_WRAP_IE_BIT],
               line_config_field:  line_mode_e'(wbyte[`CTL_LINE_HI_BIT:`CTL_LINE_LO_BIT]),
               shift_clock_select: clk_src_e'(wbyte[`CTL_CLKSEL_HI_BIT:`CTL_CLKSEL_LO_BIT]),
               clock_strobe_bit:   clk_sel_wr & wbyte[`CTL_CLK_STROBE_BIT]} :
    ctl_r;

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      ctl_r <= control_s'(7'(`SER_CONTROL_RST));
    else
      ctl_r <= ctl_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // data, counter and buffer

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      data_r <= `SER_DATA_RST;
      cnt_r  <= `SER_COUNT_RST;
      buf_r  <= `SER_BUFFER_RST;
    end
    else
    begin
      data_r <= data_nxt;
      cnt_r  <= cnt_nxt;
      if (wrap_evt)
        buf_r <= data_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags, hold and latch

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      start_flag_r <= 1'b0;
      wrap_flag_r  <= 1'b0;
      stop_flag_r  <= 1'b0;
      start_hold_r <= 1'b0;
      latch_r      <= 1'b1;
    end
    else
    begin
      start_flag_r <= start_flag_nxt;
      wrap_flag_r  <= wrap_flag_nxt;
      stop_flag_r  <= stop_flag_nxt;
      start_hold_r <= start_hold_nxt;
      if (latch_open)
        latch_r <= data_r[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers

  // overflow hold only in mode 11
  wire wrap_hold  = (ctl_r.line_config_field == LINE_TWO_WIRE_HOLD) & wrap_flag_r;
  wire clock_hold = two_wire & (start_hold_r | wrap_hold);

  // three-wire drives latch level, two-wire pulls low only
  assign DATA_DRIVE_OUT.level = two_wire ? 1'b0 : latch_r;
  assign DATA_DRIVE_OUT.oe    = PORT_DIR_DATA_IN & ~wire_off &
                                (~two_wire | ~latch_r | ~PORT_OUT_DATA_IN);
  // clock pin: open-drain low by port bit or hold in two-wire
  assign CLOCK_DRIVE_OUT.level = 1'b0;
  assign CLOCK_DRIVE_OUT.oe    = PORT_DIR_CLOCK_IN & two_wire &
                                 (clock_hold | ~PORT_OUT_CLOCK_IN);

  ////////////////////////////////////////////////////////////////////////////
  // interrupts and wake

  // pending flag fires as soon as enabled
  assign START_IRQ_OUT      = start_flag_r & ctl_r.start_irq_enable & GLOBAL_IRQ_EN_IN;
  assign WRAP_IRQ_OUT       = wrap_flag_r & ctl_r.wrap_irq_enable & GLOBAL_IRQ_EN_IN;
  assign WAKE_ANY_SLEEP_OUT = start_flag_r & ctl_r.start_irq_enable;
  assign WAKE_IDLE_OUT      = wrap_flag_r & ctl_r.wrap_irq_enable;

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup cycle

  // mismatch between bit 7 and pin
  wire       mismatch = data_r[7] ^ sda_s_r;
  wire [7:0] sts_rd   = {start_flag_r, wrap_flag_r, stop_flag_r, mismatch, cnt_r};
  wire [7:0] ctl_rd   = {ctl_r.start_irq_enable, ctl_r.wrap_irq_enable,
                         ctl_r.line_config_field, ctl_r.shift_clock_select,
                         ctl_r.clock_strobe_bit, 1'b0};
  // buffer read has no side effect, same as data read
  wire [7:0] rd_byte  = ~mapped  ? 8'h00 :
                        hit_ctl  ? ctl_rd :
                        hit_sts  ? sts_rd :
                        hit_data ? data_r : buf_r;

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      prdata_r <= 32'h0000_0000;
    else if (setup_rd)
      prdata_r <= {24'h00_0000, rd_byte};
  end

endmodule

// ### bench/serial_peer_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
// far-side master: its clock stands low outside frames
module serial_peer_model
(
  output logic clk_pin_out,
  output logic data_pin_out
);
  // idle levels at time zero
  initial
  begin
    clk_pin_out  = 1'b0;
    data_pin_out = 1'b1;
  end
  // one frame, msb first, data changes while the clock is low
  task automatic send(input logic [7:0] b);
    #13;
    for (int i = 7; i >= 0; i--)
    begin
      data_pin_out = b[i];
      #200;
      clk_pin_out = 1'b1;
      #200;
      clk_pin_out = 1'b0;
    end
    // released line shows the inverse of the last bit
    data_pin_out = ~b[0];
  endtask
endmodule

// ### bench/universal_serial_shift_core_sva.sv
`timescale 1ns/10ps
module universal_serial_shift_core_sva
(
  input wire logic                    CLK_IN,
  input wire logic                    RST_N_IN,
  input wire logic                    PSEL_IN,
  input wire logic                    PENABLE_IN,
  input wire logic                    PWRITE_IN,
  input wire logic [7:0]              PADDR_IN,
  input wire logic [31:0]             PWDATA_IN,
  input wire logic                    PORT_DIR_DATA_IN,
  input wire logic                    PORT_DIR_CLOCK_IN,
  input wire logic                    GLOBAL_IRQ_EN_IN,
  input serial_shift_pkg::pin_drive_s DATA_DRIVE_OUT,
  input serial_shift_pkg::pin_drive_s CLOCK_DRIVE_OUT,
  input wire logic                    PIN_TOGGLE_OUT,
  input wire logic                    START_IRQ_OUT,
  input wire logic                    WRAP_IRQ_OUT,
  input wire logic                    WAKE_ANY_SLEEP_OUT,
  input wire logic                    WAKE_IDLE_OUT
);
  import serial_shift_pkg::*;
  logic [7:0] ctl_r;
  logic       wr;
  // bus write strobe
  assign wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
  // shadow of the stored control bits
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      ctl_r <= 8'h00;
    else if (wr && PADDR_IN == 8'h34)
      ctl_r <= PWDATA_IN[7:0];
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  ////////////////////////////////////////////////////////////
  property p_start_irq;
    START_IRQ_OUT |-> GLOBAL_IRQ_EN_IN && ctl_r[7] && WAKE_ANY_SLEEP_OUT;
  endproperty
  a_start_irq: assert property (p_start_irq) else $error("start irq bad");
  property p_wrap_irq;
    WRAP_IRQ_OUT |-> GLOBAL_IRQ_EN_IN && ctl_r[6] && WAKE_IDLE_OUT;
  endproperty
  a_wrap_irq: assert property (p_wrap_irq) else $error("wrap irq bad");
  property p_start_hold;
    WAKE_ANY_SLEEP_OUT && !wr |=> WAKE_ANY_SLEEP_OUT;
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start lost");
  property p_wrap_hold;
    WAKE_IDLE_OUT && !wr |=> WAKE_IDLE_OUT;
  endproperty
  a_wrap_hold: assert property (p_wrap_hold) else $error("wrap lost");
  property p_off_mode;
    ctl_r[5:4] == 2'b00 |-> !DATA_DRIVE_OUT.oe && !CLOCK_DRIVE_OUT.oe;
  endproperty
  a_off_mode: assert property (p_off_mode) else $error("driver on");
  property p_data_dir;
    DATA_DRIVE_OUT.oe |-> PORT_DIR_DATA_IN;
  endproperty
  a_data_dir: assert property (p_data_dir) else $error("data oe bad");
  property p_clk_hold;
    CLOCK_DRIVE_OUT.oe |-> ctl_r[5] && PORT_DIR_CLOCK_IN && !CLOCK_DRIVE_OUT.level;
  endproperty
  a_clk_hold: assert property (p_clk_hold) else $error("clock oe bad");
  property p_toggle;
    PIN_TOGGLE_OUT |-> wr && PADDR_IN == 8'h34 && PWDATA_IN[0];
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle bad");
  property p_toggle_one;
    PIN_TOGGLE_OUT |=> !PIN_TOGGLE_OUT;
  endproperty
  a_toggle_one: assert property (p_toggle_one) else $error("toggle long");
  c_wrap: cover property (WRAP_IRQ_OUT);
  c_start: cover property (START_IRQ_OUT);
  c_toggle: cover property (PIN_TOGGLE_OUT);
endmodule

bind universal_serial_shift_core universal_serial_shift_core_sva chk_u
(
  .CLK_IN, .RST_N_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN,
  .PWDATA_IN, .PORT_DIR_DATA_IN, .PORT_DIR_CLOCK_IN, .GLOBAL_IRQ_EN_IN,
  .DATA_DRIVE_OUT, .CLOCK_DRIVE_OUT, .PIN_TOGGLE_OUT, .START_IRQ_OUT,
  .WRAP_IRQ_OUT, .WAKE_ANY_SLEEP_OUT, .WAKE_IDLE_OUT
);

// ### bench/universal_serial_shift_core_bench.sv
`timescale 1ns/10ps
module universal_serial_shift_core_bench;
  import serial_shift_pkg::*;
  localparam logic [7:0] CTL = 8'h34;
  localparam logic [7:0] STS = 8'h38;
  localparam logic [7:0] DAT = 8'h3C;
  localparam logic [7:0] BUF = 8'h40;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tmr;
  logic        sck;
  logic        sdi;
  logic        start_irq;
  logic        wrap_irq;
  logic        wake_any;
  logic        wake_idle;
  pin_drive_s  dd;
  logic [7:0]  rd_v;
  logic        err_v;
  logic [7:0]  ctl_tab [2] = '{8'hD8, 8'h08};
  logic [7:0]  byte_tab [2] = '{8'hA5, 8'h3C};
  int          failures;
  int          n_checks;
  serial_peer_model peer_u (.clk_pin_out(sck), .data_pin_out(sdi));
  universal_serial_shift_core dut_u
  (
    .CLK_IN             (clk),
    .RST_N_IN           (rst_n),
    .PSEL_IN            (psel),
    .PENABLE_IN         (pen),
    .PWRITE_IN          (pwr),
    .PADDR_IN           (paddr),
    .PWDATA_IN          (pwdata),
    .PRDATA_OUT         (prdata),
    .PREADY_OUT         (pready),
    .PSLVERR_OUT        (pslverr),
    .SERIAL_IN_PIN_IN   (sdi),
    .SHIFT_CLOCK_PIN_IN (sck),
    .PORT_DIR_DATA_IN   (1'b1),
    .PORT_DIR_CLOCK_IN  (1'b1),
    .PORT_OUT_DATA_IN   (1'b1),
    .PORT_OUT_CLOCK_IN  (1'b0),
    .TIMER0_MATCH_IN    (tmr),
    .GLOBAL_IRQ_EN_IN   (1'b1),
    .DATA_DRIVE_OUT     (dd),
    .CLOCK_DRIVE_OUT    (),
    .PIN_TOGGLE_OUT     (),
    .START_IRQ_OUT      (start_irq),
    .WRAP_IRQ_OUT       (wrap_irq),
    .WAKE_ANY_SLEEP_OUT (wake_any),
    .WAKE_IDLE_OUT      (wake_idle)
  );
  // 20 MHz clock
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one bus transfer, optional timer pulse in the access cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic t);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    tmr <= t;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 20)
      failures++;
    rd_v  = prdata[7:0];
    err_v = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    tmr  <= 1'b0;
  endtask
  // compare one value
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  // read a register and compare the masked bits
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, a, 8'h00, 1'b0);
    chk($sformatf("reg %h", a), e, rd_v & m);
  endtask
  ////////////////////////////////////////////////////////////
  // watchdog
  initial
  begin
    #500000;
    failures++;
    report_and_stop();
  end
  // main sequence
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    tmr = 1'b0;
    failures = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(CTL, 8'hFF, 8'h00);
    rchk(DAT, 8'hFF, 8'h00);
    rchk(BUF, 8'hFF, 8'h00);
    apb(1'b0, 8'h44, 8'h00, 1'b0);
    chk("unmapped error", 8'h01, {7'h00, err_v});
    chk("unmapped data", 8'h00, rd_v);
    // software strobe, idle data line is high
    wr(DAT, 8'h81);
    wr(STS, 8'hF0);
    wr(CTL, 8'h02);
    rchk(DAT, 8'hFF, 8'h03);
    rchk(STS, 8'h0F, 8'h01);
    // timer clock against a data write, then alone
    wr(CTL, 8'h44);
    wr(STS, 8'hFF);
    apb(1'b1, DAT, 8'h5A, 1'b1);
    rchk(DAT, 8'hFF, 8'h5A);
    rchk(STS, 8'hEF, 8'h40);
    chk("wrap irq", 8'h01, {7'h00, wrap_irq});
    chk("wake idle", 8'h01, {7'h00, wake_idle});
    wr(STS, 8'h4F);
    rchk(STS, 8'hEF, 8'h0F);
    chk("wrap irq", 8'h00, {7'h00, wrap_irq});
    apb(1'b0, DAT, 8'h00, 1'b1);
    rchk(BUF, 8'hFF, 8'hB5);
    rchk(STS, 8'hEF, 8'h40);
    // toggle strobe clocks an external source
    wr(CTL, 8'h0A);
    wr(STS, 8'hF0);
    wr(CTL, 8'h0B);
    wr(CTL, 8'h0B);
    rchk(STS, 8'h0F, 8'h02);
    rchk(DAT, 8'hFF, 8'hD7);
    // external frames in three-wire and outputs-off modes
    foreach (ctl_tab[i])
    begin
      wr(CTL, ctl_tab[i]);
      wr(STS, 8'hF0);
      peer_u.send(byte_tab[i]);
      repeat (4) @(posedge clk);
      rchk(BUF, 8'hFF, byte_tab[i]);
      rchk(DAT, 8'hFF, byte_tab[i]);
      rchk(STS, 8'hEF, 8'hC0);
      chk("start irq", {7'h00, ctl_tab[i][7]}, {7'h00, start_irq});
      chk("data oe", {7'h00, ctl_tab[i][4]}, {7'h00, dd.oe});
    end
    // two-wire mode, then outputs off with start enable and flag pending
    wr(CTL, 8'h20);
    wr(CTL, 8'h88);
    @(posedge clk);
    chk("start irq", 8'h01, {7'h00, start_irq});
    chk("wake any", 8'h01, {7'h00, wake_any});
    report_and_stop();
  end
endmodule
